// [core/i2cb_map.svh]
// Constant map of the two-wire byte transfer engine
`ifndef I2CB_MAP_SVH
`define I2CB_MAP_SVH
`define I2CB_CLK_NS 25
`define I2CB_QTR_NS 2500
`define I2CB_QTR_CYC ((`I2CB_QTR_NS + `I2CB_CLK_NS - 1) / `I2CB_CLK_NS)
`define I2CB_QTR_LAST 8'((`I2CB_QTR_CYC) - 1)
`define I2CB_ACK_BIT 4'h8
`define I2CB_TEN_PFX 5'h1e
`define I2CB_DIR_WR 1'b0
`define I2CB_DIR_RD 1'b1
`define I2CB_PH_0 2'h0
`define I2CB_PH_1 2'h1
`define I2CB_PH_2 2'h2
`define I2CB_PH_3 2'h3
`define I2CB_SYNC_SCL 0
`define I2CB_SYNC_SDA 1
`endif

// [core/i2cb_pkg.sv]
// Types of the two-wire byte transfer engine
package i2cb_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_START = 7'h02,
    ST_TXB = 7'h04,
    ST_RXB = 7'h08,
    ST_HOLD = 7'h10,
    ST_RSTART = 7'h20,
    ST_STOP = 7'h40
  } i2cb_state_t;

  typedef enum logic [3:0] {
    SP_A1 = 4'h1,
    SP_A2 = 4'h2,
    SP_A1R = 4'h4,
    SP_DAT = 4'h8
  } i2cb_step_t;

  typedef struct packed {
    i2cb_state_t st;
    i2cb_step_t step;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [9:0] addr;
    logic ten;
    logic rd;
    logic scl_oe;
    logic sda_oe;
    logic pend;
    logic nack;
  } i2cb_eng_t;
endpackage

// [core/i2cb_sync.sv]
// Two-flop synchroniser for the bus line inputs
`timescale 1ns/1ps
`default_nettype none
module i2cb_sync (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [1:0] d_i, // Asynchronous line levels
  output logic [1:0] q_o // Synchronised levels
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } i2cb_sync_t;

  i2cb_sync_t r;
  i2cb_sync_t n;

  always_comb begin
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  // Idle bus lines are high, so reset to high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;
endmodule
`default_nettype wire

// [core/i2cb_buf2.sv]
// Small valid/ready buffer for byte data
`timescale 1ns/1ps
`default_nettype none
module i2cb_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [W-1:0] in_data_i, // Fill side data
  input wire logic in_valid_i, // Fill side valid
  output logic in_ready_o, // Fill side ready, low when full
  output logic [W-1:0] out_data_o, // Drain side data
  output logic out_valid_o, // Drain side valid, low when empty
  input wire logic out_ready_i // Drain side ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } i2cb_bufst_t;

  i2cb_bufst_t r;
  i2cb_bufst_t n;
  logic push;
  logic pop;

  assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_i;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// [core/i2cb_engine.sv]
// Master byte transfer engine of the two-wire serial bus
//
// How it works
// RULE_01: every byte shifts exactly eight data bits, one per clock pulse.
// RULE_02: no byte count limit between Start and Stop.
// RULE_03: the address byte is sent first after every Start or repeated Start.
// RULE_04: a ninth clock pulse carries the acknowledge after eight data pulses.
// RULE_05: address and data bytes go out most significant bit first.
// RULE_06: 7-bit write: Start, address, direction 0, ack, acked data, Stop.
// RULE_07: 10-bit write: 11110 prefix byte, second address byte, acked data, Stop.
// RULE_08: 7-bit read: address with direction 1, slave ack, master acks data.
// RULE_09: 10-bit read: two address bytes, repeated Start, first byte with direction 1.
// RULE_10: the master generates the acknowledge clock pulse in both directions.
// RULE_11: the transmitter releases the data line during the acknowledge pulse.
// RULE_12: the receiver holds data low through the high half of pulse nine.
// RULE_13: acknowledge can be disabled, yet the ninth pulse is always made.
// RULE_14: after a sent byte, clock stays low until new data is written; the engine does so only after data bytes and a write's last address byte.
// RULE_15: each sent byte raises pending; processor answers with the next byte.
// RULE_16: after a received byte, clock stays low until the byte is read.
// RULE_17: each received byte raises pending; processor answers by reading it.
// RULE_18: eighth address bit: 0 is write, 1 is read.
// RULE_19: Start is data falling while clock is high.
// RULE_20: Stop is data rising while clock is high, ending the transfer.
// RULE_21: 10-bit first byte carries the two top address bits after the prefix.
`timescale 1ns/1ps
`default_nettype none
`include "i2cb_map.svh"
module i2cb_engine (
  input wire logic clk_i, // Core clock, 40 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic scl_i, // Serial clock line level
  output logic scl_o, // Serial clock drive value, always low
  output logic scl_oe_o, // Serial clock pull-low enable
  input wire logic sda_i, // Serial data line level
  output logic sda_o, // Serial data drive value, always low
  output logic sda_oe_o, // Serial data pull-low enable
  input wire logic cmd_start_i, // Pulse: Start with the given address
  input wire logic [9:0] addr_i, // Slave address
  input wire logic ten_bit_i, // Address is 10 bits wide
  input wire logic read_i, // Transfer direction is read
  input wire logic stop_req_i, // Level: end the transfer at next byte gap
  input wire logic ack_en_i, // Level: acknowledge received bytes
  input wire logic [7:0] tx_data_i, // Byte written to the shift data register
  input wire logic tx_valid_i, // Write strobe of the shift data register
  output logic tx_ready_o, // Write side has room
  output logic [7:0] rx_data_o, // Byte read from the shift data register
  output logic rx_valid_o, // Received byte waiting
  input wire logic rx_ready_i, // Read strobe of the shift data register
  output logic pend_o, // Byte completion pending
  output logic busy_o, // Transfer in progress
  output logic hold_o, // Serial clock held low between bytes
  output logic nack_o // Acknowledge slot of the last sent byte read high
);
  import i2cb_pkg::*;

  i2cb_eng_t r;
  i2cb_eng_t n;
  logic [1:0] lines_s;
  logic scl_s;
  logic sda_s;
  logic adv;
  logic tx_pop;
  logic [7:0] tx_q;
  logic tx_q_vld;
  logic rx_push;
  logic rx_room;
  logic byte_end;

  // Both lines pass two flops before any logic reads them
  i2cb_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({sda_i, scl_i}),
    .q_o(lines_s)
  );

  assign scl_s = lines_s[`I2CB_SYNC_SCL];
  assign sda_s = lines_s[`I2CB_SYNC_SDA];

  // Written bytes wait here so a fast writer loses nothing
  i2cb_buf2 #(
    .W(8),
    .DEPTH(2)
  ) u_txbuf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(tx_q),
    .out_valid_o(tx_q_vld),
    .out_ready_i(tx_pop)
  );

  // Received bytes wait here; reception resumes only once it is empty
  i2cb_buf2 #(
    .W(8),
    .DEPTH(2)
  ) u_rxbuf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(r.sh),
    .in_valid_i(rx_push),
    .in_ready_o(rx_room),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // First address byte: 7-bit form or 11110 prefix with top two bits
  function automatic logic [7:0] first_byte(input logic [9:0] a, input logic ten, input logic dir);
    logic [7:0] b;
    if (ten) begin
      b = {`I2CB_TEN_PFX, a[9:8], dir}; // see RULE_21
    end else begin
      b = {a[6:0], dir}; // see RULE_18
    end
    return b;
  endfunction

  // A released clock that still reads low is a stretching slave; wait
  assign adv = (r.qcnt == `I2CB_QTR_LAST) && (r.scl_oe || scl_s);
  assign byte_end = adv && (r.ph == `I2CB_PH_3) && (r.bitn == `I2CB_ACK_BIT);
  assign rx_push = (r.st == ST_RXB) && byte_end;

  // One pass: quarter timer, pending flag, then the state step
  always_comb begin
    n = r;
    tx_pop = 1'b0;
    if (r.st != ST_IDLE && r.st != ST_HOLD) begin
      if ((!r.scl_oe && !scl_s) || adv) begin
        n.qcnt = 8'h00;
      end else begin
        n.qcnt = r.qcnt + 8'h01;
      end
      if (adv) begin
        n.ph = r.ph + 2'h1;
      end
    end
    // Processor access clears pending; a new completion below wins
    if ((tx_valid_i && tx_ready_o) || (rx_valid_o && rx_ready_i)) begin
      n.pend = 1'b0; // see RULE_15, RULE_17
    end
    case (r.st)
      ST_IDLE: begin
        // Both lines released while idle
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (cmd_start_i) begin
          n.addr = addr_i;
          n.ten = ten_bit_i;
          n.rd = read_i;
          n.nack = 1'b0;
          n.st = ST_START;
          n.ph = `I2CB_PH_0;
          n.qcnt = 8'h00;
        end
      end
      ST_START: begin
        if (adv) begin
          case (r.ph)
            `I2CB_PH_1: begin
              n.sda_oe = 1'b1; // see RULE_19
            end
            `I2CB_PH_2: begin
              n.scl_oe = 1'b1;
            end
            `I2CB_PH_3: begin
              n.sh = first_byte(r.addr, r.ten, r.ten ? `I2CB_DIR_WR : r.rd); // see RULE_03, RULE_06, RULE_08
              n.step = SP_A1;
              n.bitn = 4'h0;
              n.st = ST_TXB;
            end
            default: begin
            end
          endcase
        end
      end
      ST_TXB, ST_RXB: begin
        if (adv) begin
          case (r.ph)
            `I2CB_PH_0: begin
              if (r.st == ST_TXB) begin
                // Ack slot released for the slave
                n.sda_oe = (r.bitn == `I2CB_ACK_BIT) ? 1'b0 : ~r.sh[7]; // see RULE_05, RULE_11
              end else begin
                // Disabled ack leaves the line high on pulse nine
                n.sda_oe = (r.bitn == `I2CB_ACK_BIT) ? ack_en_i : 1'b0; // see RULE_12, RULE_13
              end
            end
            `I2CB_PH_1: begin
              n.scl_oe = 1'b0; // see RULE_10
            end
            `I2CB_PH_2: begin
              if (r.bitn == `I2CB_ACK_BIT) begin
                if (r.st == ST_TXB) begin
                  n.nack = sda_s;
                end
              end else if (r.st == ST_TXB) begin
                n.sh = {r.sh[6:0], 1'b0};
              end else begin
                n.sh = {r.sh[6:0], sda_s}; // see RULE_05
              end
            end
            default: begin
              // Clock pulled low ends the bit
              n.scl_oe = 1'b1;
              if (r.bitn == `I2CB_ACK_BIT) begin
                n.bitn = 4'h0;
                n.pend = 1'b1; // see RULE_15, RULE_17
                if (r.st == ST_TXB && r.step == SP_A1 && r.ten) begin
                  n.sh = r.addr[7:0]; // see RULE_07, RULE_09
                  n.step = SP_A2;
                end else if (r.st == ST_TXB && r.step == SP_A1R) begin
                  n.step = SP_DAT;
                  n.st = ST_HOLD;
                end else begin
                  n.st = ST_HOLD; // see RULE_14, RULE_16
                end
              end else begin
                n.bitn = r.bitn + 4'h1; // see RULE_01, RULE_04
              end
            end
          endcase
        end
      end
      ST_HOLD: begin
        // Clock held low; a master ack level stays on data meanwhile
        n.scl_oe = 1'b1;
        n.qcnt = 8'h00;
        n.ph = `I2CB_PH_0;
        // A start request wins over stop and over queued data
        if (cmd_start_i) begin
          n.addr = addr_i;
          n.ten = ten_bit_i;
          n.rd = read_i;
          n.nack = 1'b0;
          n.step = SP_A1;
          n.st = ST_RSTART; // see RULE_03
        end else if (r.step == SP_A2 && r.rd) begin
          n.step = SP_A1R;
          n.st = ST_RSTART; // see RULE_09
        end else if (stop_req_i) begin
          n.st = ST_STOP; // see RULE_06
        end else if (r.rd) begin
          // Resume only once the last byte has been taken
          if (!rx_valid_o && rx_room) begin
            n.step = SP_DAT;
            n.sh = 8'h00;
            n.st = ST_RXB; // see RULE_02, RULE_08, RULE_16
          end
        end else if (tx_q_vld) begin
          tx_pop = 1'b1;
          n.step = SP_DAT;
          n.sh = tx_q;
          n.st = ST_TXB; // see RULE_02, RULE_14
        end
      end
      ST_RSTART: begin
        // Data released first so that its fall comes under a high clock
        if (adv) begin
          case (r.ph)
            `I2CB_PH_0: begin
              n.sda_oe = 1'b0;
            end
            `I2CB_PH_1: begin
              n.scl_oe = 1'b0;
            end
            `I2CB_PH_2: begin
              n.sda_oe = 1'b1; // see RULE_19
            end
            default: begin
              n.scl_oe = 1'b1;
              n.bitn = 4'h0;
              n.nack = 1'b0;
              if (r.step == SP_A1R) begin
                n.sh = first_byte(r.addr, 1'b1, `I2CB_DIR_RD); // see RULE_09
              end else begin
                n.sh = first_byte(r.addr, r.ten, r.ten ? `I2CB_DIR_WR : r.rd); // see RULE_03
              end
              n.st = ST_TXB;
            end
          endcase
        end
      end
      ST_STOP: begin
        // Data pulled low first so that it can rise under a high clock
        if (adv) begin
          case (r.ph)
            `I2CB_PH_0: begin
              n.sda_oe = 1'b1;
            end
            `I2CB_PH_1: begin
              n.scl_oe = 1'b0;
            end
            `I2CB_PH_2: begin
              n.sda_oe = 1'b0; // see RULE_20
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Lines released, nothing pending
      r.st <= ST_IDLE;
      r.step <= SP_A1;
      r.ph <= `I2CB_PH_0;
      r.qcnt <= '0;
      r.bitn <= '0;
      r.sh <= '0;
      r.addr <= '0;
      r.ten <= 1'b0;
      r.rd <= 1'b0;
      r.scl_oe <= 1'b0;
      r.sda_oe <= 1'b0;
      r.pend <= 1'b0;
      r.nack <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // Open-drain lines: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = r.scl_oe;
  assign sda_oe_o = r.sda_oe;
  assign pend_o = r.pend;
  assign busy_o = (r.st != ST_IDLE);
  assign hold_o = (r.st == ST_HOLD);
  assign nack_o = r.nack;
endmodule
`default_nettype wire

// [test/i2cb_engine_props.sv]
// Port checker of the two-wire byte engine
`timescale 1ns/1ps
`default_nettype none
module i2cb_engine_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic cmd_start_i,
  input wire logic [9:0] addr_i,
  input wire logic ten_bit_i,
  input wire logic read_i,
  input wire logic stop_req_i,
  input wire logic ack_en_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic [7:0] rx_data_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic pend_o,
  input wire logic busy_o,
  input wire logic hold_o,
  input wire logic nack_o
);
  logic [4:0] rel_cnt_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Clock releases since the last byte gap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rel_cnt_r <= 5'h00;
    else if ($fell(hold_o) || $rose(busy_o)) rel_cnt_r <= 5'h00;
    else if ($fell(scl_oe_o)) rel_cnt_r <= rel_cnt_r + 5'h01;
  end
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("line drive value not low");
  nine_pulse_a: assert property ($rose(hold_o) |-> rel_cnt_r inside {5'h09, 5'h0a, 5'h12, 5'h13})
    else $error("pulse count per byte wrong");
  hold_low_a: assert property (hold_o |-> scl_oe_o) else $error("clock released in byte gap");
  start_go_a: assert property (cmd_start_i && !busy_o |=> busy_o) else $error("start not taken");
  start_cond_a: assert property ($rose(busy_o) |-> !scl_oe_o throughout (##[1:300] $rose(sda_oe_o)))
    else $error("start not data fall with clock high");
  stop_cond_a: assert property ($fell(sda_oe_o) && !scl_oe_o |-> ##[1:300] !busy_o)
    else $error("stop did not end transfer");
  pend_keep_a: assert property (pend_o && !(tx_valid_i && tx_ready_o) && !(rx_valid_o && rx_ready_i) |=> pend_o)
    else $error("pending dropped without access");
  rx_wait_a: assert property (hold_o && rx_valid_o && !rx_ready_i && !stop_req_i && !cmd_start_i |=> hold_o)
    else $error("clock resumed before byte read");
  nack_clr_a: assert property (cmd_start_i && (!busy_o || hold_o) |=> !nack_o) else $error("nack kept at start");
  gap_pend_a: assert property ($rose(hold_o) |-> ##[0:2] pend_o) else $error("no pending at byte end");
  cover property ($rose(nack_o));
  cover property (hold_o && rx_valid_o);
  cover property (tx_valid_i && !tx_ready_o);
  cover property ($fell(busy_o));
endmodule
bind i2cb_engine i2cb_engine_props i_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cmd_start_i(cmd_start_i),
  .addr_i(addr_i), .ten_bit_i(ten_bit_i), .read_i(read_i), .stop_req_i(stop_req_i), .ack_en_i(ack_en_i),
  .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .pend_o(pend_o), .busy_o(busy_o), .hold_o(hold_o),
  .nack_o(nack_o));
`default_nettype wire

// [test/i2cb_slave_model.sv]
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2cb_slave_model (
  input wire logic scl_i, // Clock level
  input wire logic sda_i, // Data level
  input wire logic stretch_i, // Stall clock
  input wire logic nak_i, // Refuse address
  input wire logic [7:0] rd_byte_i, // First read byte
  output logic scl_oe_o, // Pull clock low
  output logic sda_oe_o // Pull data low
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rdb = 8'h00;
  logic rd_mode = 1'b0;
  logic first = 1'b0;
  logic sack = 1'b1;
  int bitc = 8;
  int n_start = 0;
  int n_stop = 0;
  logic [7:0] rx_q[$];
  logic ack_q[$];
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    bitc = -1;
    first = 1'b1;
    n_start++;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) n_stop++;
  always @(posedge scl_i) begin
    if (bitc < 8) sh = {sh[6:0], sda_i};
    else begin
      sack = sda_i;
      if (rd_mode && !first) ack_q.push_back(sda_i);
    end
  end
  // Data moves a little after the fall to give hold time
  always @(negedge scl_i) begin
    #5;
    if (bitc == 7) begin
      if (first || !rd_mode) begin
        rx_q.push_back(sh);
        sda_oe_o = !nak_i;
      end else sda_oe_o = 1'b0;
      if (first) rd_mode = sh[0];
      bitc = 8;
    end else if (bitc == 8) begin
      sda_oe_o = 1'b0;
      rdb = first ? rd_byte_i : ~rdb;
      first = 1'b0;
      bitc = 0;
      if (rd_mode && !sack) sda_oe_o = !rdb[7];
    end else begin
      bitc++;
      if (rd_mode && !first) sda_oe_o = !rdb[7 - bitc];
    end
  end
  // Stall outlasts the master's low phase, so the clock rise must wait
  always @(negedge scl_i) if (stretch_i) begin
    scl_oe_o = 1'b1;
    #6000;
    scl_oe_o = 1'b0;
  end
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the two-wire byte engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_start_i = 1'b0;
  logic ten_bit_i = 1'b0;
  logic read_i = 1'b0;
  logic stop_req_i = 1'b0;
  logic ack_en_i = 1'b1;
  logic tx_valid_i = 1'b0;
  logic rx_ready_i = 1'b0;
  logic stretch = 1'b0;
  logic nak = 1'b0;
  logic [9:0] addr_i = 10'h000;
  logic [7:0] tx_data_i = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] rx_data_o;
  logic scl_o, sda_o, scl_oe_o, sda_oe_o, tx_ready_o, rx_valid_o, pend_o, busy_o, hold_o, nack_o, s_scl, s_sda;
  int n_fail = 0;
  int samples_checked = 0;
  // Pull-ups: a line is low while any party pulls it
  wire logic scl_w = !(scl_oe_o || s_scl);
  wire logic sda_w = !(sda_oe_o || s_sda);
  i2cb_engine i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cmd_start_i(cmd_start_i), .addr_i(addr_i),
    .ten_bit_i(ten_bit_i), .read_i(read_i), .stop_req_i(stop_req_i), .ack_en_i(ack_en_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .pend_o(pend_o), .busy_o(busy_o), .hold_o(hold_o), .nack_o(nack_o));
  i2cb_slave_model i_slv (.scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch), .nak_i(nak), .rd_byte_i(rd_byte),
    .scl_oe_o(s_scl), .sda_oe_o(s_sda));
  initial forever #12.5 clk_i = !clk_i;
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Kinds: 0 gap, 1 gap with byte waiting, 2 idle, 3 gap after n slave bytes
  task automatic wait_on(input int kind, input int n);
    for (int i = 0; i < 30000; i++) begin
      @(posedge clk_i);
      if (kind == 0 ? hold_o === 1'b1 : kind == 1 ? (hold_o & rx_valid_o) === 1'b1 :
          kind == 2 ? busy_o === 1'b0 : i_slv.rx_q.size() == n && hold_o === 1'b1) return;
    end
    chk("wait", 0, 1);
    print_verdict();
  endtask
  task automatic go(input logic [9:0] a, input logic ten, input logic rd);
    i_slv.rx_q.delete();
    i_slv.ack_q.delete();
    i_slv.n_start = 0;
    i_slv.n_stop = 0;
    @(posedge clk_i);
    cmd_start_i <= 1'b1;
    addr_i <= a;
    ten_bit_i <= ten;
    read_i <= rd;
    @(posedge clk_i);
    cmd_start_i <= 1'b0;
  endtask
  task automatic put(input logic [7:0] b);
    int i;
    i = 0;
    @(posedge clk_i);
    tx_data_i <= b;
    tx_valid_i <= 1'b1;
    do @(posedge clk_i); while (tx_ready_o !== 1'b1 && ++i < 20000);
    tx_valid_i <= 1'b0;
    if (i >= 20000) begin
      chk("tx_wait", 0, 1);
      print_verdict();
    end
  endtask
  task automatic take(input logic [7:0] exp);
    chk("pend", pend_o, 1);
    chk("rx_data", rx_data_o, exp);
    rx_ready_i <= 1'b1;
    @(posedge clk_i);
    rx_ready_i <= 1'b0;
  endtask
  task automatic fin();
    @(posedge clk_i);
    stop_req_i <= 1'b1;
    wait_on(2, 0);
    stop_req_i <= 1'b0;
    chk("stops", i_slv.n_stop, 1);
  endtask
  task automatic s_write7();
    stretch <= 1'b1;
    go(10'h05b, 1'b0, 1'b0);
    wait_on(0, 0);
    chk("pend", pend_o, 1);
    repeat (400) @(posedge clk_i);
    chk("scl", scl_w, 0);
    chk("bytes", i_slv.rx_q.size(), 1);
    put(8'hc5);
    @(posedge clk_i);
    chk("pend", pend_o, 0);
    put(8'h3e);
    put(8'h81);
    @(posedge clk_i);
    chk("tx_ready", tx_ready_o, 0);
    wait_on(3, 4);
    fin();
    chk("frame", {i_slv.rx_q[0], i_slv.rx_q[1]}, {8'hb6, 8'hc5});
    chk("frame", {i_slv.rx_q[2], i_slv.rx_q[3]}, {8'h3e, 8'h81});
    stretch <= 1'b0;
  endtask
  task automatic s_read7();
    rd_byte <= 8'h96;
    ack_en_i <= 1'b1;
    go(10'h03a, 1'b0, 1'b1);
    wait_on(1, 0);
    chk("scl", scl_w, 0);
    chk("addr", i_slv.rx_q[0], 8'h75);
    ack_en_i <= 1'b0;
    take(8'h96);
    wait_on(1, 0);
    fin();
    take(8'h69);
    chk("acks", {i_slv.ack_q[0], i_slv.ack_q[1]}, 2'b01);
  endtask
  task automatic s_write10();
    go(10'h2b6, 1'b1, 1'b0);
    wait_on(3, 2);
    chk("pend", pend_o, 1);
    put(8'h3c);
    wait_on(3, 3);
    fin();
    chk("frame", {i_slv.rx_q[0], i_slv.rx_q[1], i_slv.rx_q[2]}, 24'hf4_b63c);
  endtask
  task automatic s_read10();
    rd_byte <= 8'h5a;
    go(10'h1c9, 1'b1, 1'b1);
    wait_on(1, 0);
    chk("frame", {i_slv.rx_q[0], i_slv.rx_q[1], i_slv.rx_q[2]}, 24'hf2_c9f3);
    chk("starts", i_slv.n_start, 2);
    fin();
    take(8'h5a);
    chk("ack", i_slv.ack_q[0], 1);
  endtask
  task automatic s_nack();
    nak <= 1'b1;
    go(10'h011, 1'b0, 1'b0);
    wait_on(0, 0);
    chk("nack", nack_o, 1);
    nak <= 1'b0;
    go(10'h011, 1'b0, 1'b1);
    @(posedge clk_i);
    chk("nack", nack_o, 0);
    wait_on(1, 0);
    chk("addr", i_slv.rx_q[0], 8'h23);
    chk("starts", i_slv.n_start, 1);
    fin();
    take(8'h5a);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    s_write7();
    s_read7();
    s_write10();
    s_read10();
    s_nack();
    print_verdict();
  end
endmodule
`default_nettype wire
